// ---- line_unit_irq_map.svh ----
`ifndef LINE_UNIT_IRQ_MAP_SVH
`define LINE_UNIT_IRQ_MAP_SVH

// register indexes; byte address is four times the index
`define LU_IDX_ENABLE       4'h4
`define LU_IDX_STATUS       4'h5
`define LU_IDX_SOURCE       4'h6
`define LU_IDX_CLEAR        4'h7
`define LU_IDX_CONTROL      4'h8

// bit positions shared by enable, status, source and clear
`define LU_BIT_QRSS         0
`define LU_BIT_LOS          1
`define LU_BIT_AIS          2
`define LU_BIT_LOOP_CODE    3
`define LU_BIT_CODE_VIOL    4
`define LU_BIT_FIFO_LIMIT   5
`define LU_BIT_DRIVER_ALARM 6
`define LU_EVENT_BITS       7

// control register fields
`define LU_CTRL_SINGLE_RAIL 0
`define LU_CTRL_B8ZS        1
`define LU_CTRL_BITS        2

// reset values
`define LU_ENABLE_RESET     7'h00
`define LU_SOURCE_RESET     7'h00
`define LU_CONTROL_RESET    2'h0

// bit periods without a bipolar pulse before the driver alarm
`define LU_DRIVER_IDLE_BITS 128

`endif

// ---- line_unit_irq_pkg.sv ----
package line_unit_irq_pkg;
   typedef logic [6:0] event_vec_t;
   typedef logic [31:0] apb_data_t;
   typedef enum logic [1:0] {
      APB_IDLE = 2'b00,
      APB_DONE = 2'b01,
      APB_WAIT = 2'b11
   } apb_state_e;
endpackage

// ---- level_sync.sv ----
`timescale 1ns/1ps
module level_sync #(
   parameter int WIDTH = 9
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] levelOut,
   output logic      [WIDTH-1:0] levelDly
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] dly_reg;

   // meta_reg feeds only sync_reg
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         sync_reg <= '0;
         dly_reg  <= '0;
      end else begin
         meta_reg <= asyncIn;
         sync_reg <= meta_reg;
         dly_reg  <= sync_reg;
      end
   end

   assign levelOut = sync_reg;
   assign levelDly = dly_reg;
endmodule

// ---- line_unit_interrupt_enables.sv ----
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
`include "line_unit_irq_map.svh"

// What this block does
// - Enable bit 6 gates the interrupt for every change of the transmit driver alarm.
// - With it enabled, the driver alarm raises an interrupt both when it sets and when it clears.
// - Enable bit 5 gates the interrupt for changes of the jitter FIFO pointer-limit indication.
// - Enable bit 4 lets line code violation events interrupt, and a zero masks them.
// - Enable bit 3 interrupts when loop-code detection starts and when it stops.
// - Enable bit 2 lets alarm-indication-signal detection raise an interrupt.
// - Enable bit 1 interrupts when loss of signal is declared and when it clears.
// - Enable bit 0 interrupts when the test pattern is first detected and when it is lost.
// - Enable bit 7 is unused and reads zero.
// - Source capture and the interrupt only act while single-rail mode is selected; status updates in both modes.
// - The driver alarm sets after 128 bit periods with no pulse and clears on any pulse.
// - Violation status is high on a code violation, or a long zero run when B8ZS is selected.
module line_unit_interrupt_enables
   import line_unit_irq_pkg::*;
#(
   parameter int IDLE_BITS = `LU_DRIVER_IDLE_BITS
) (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        txPulse,
   input  wire logic        txBitTick,
   input  wire logic        fifoLimit,
   input  wire logic        codeViolation,
   input  wire logic        zeroRun,
   input  wire logic        loopCodeDetect,
   input  wire logic        aisDetect,
   input  wire logic        signalLoss,
   input  wire logic        patternDetect,
   output logic             irq
);
   localparam int CW = $clog2(IDLE_BITS + 1);
   localparam logic [CW-1:0] IDLE_LIMIT = CW'(IDLE_BITS);

   function automatic logic [11:0] addrOf(input logic [3:0] idx);
      addrOf = {6'h00, idx, 2'b00};
   endfunction

   logic [8:0]  rawIn;
   logic [8:0]  syncLvl;
   logic [8:0]  syncDly;

   assign rawIn = {txPulse, txBitTick, fifoLimit, codeViolation, zeroRun,
                   loopCodeDetect, aisDetect, signalLoss, patternDetect};

   level_sync #(.WIDTH(9)) u_sync (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .asyncIn  (rawIn),
      .levelOut (syncLvl),
      .levelDly (syncDly)
   );

   logic        pulseLvl;
   logic        tickRise;
   assign pulseLvl = syncLvl[8];
   assign tickRise = syncLvl[7] & ~syncDly[7];

   // driver monitor
   logic [CW-1:0] idleCnt_reg;
   logic [CW-1:0] idleCnt_next;
   logic          driverAlarm_reg;
   logic          driverAlarm_next;

   always_comb begin
      idleCnt_next     = idleCnt_reg;
      driverAlarm_next = driverAlarm_reg;
      if (pulseLvl) begin
         idleCnt_next     = '0;
         driverAlarm_next = 1'b0;
      end else if (tickRise && idleCnt_reg != IDLE_LIMIT) begin
         idleCnt_next = idleCnt_reg + CW'(1);
         if (idleCnt_next == IDLE_LIMIT) begin
            driverAlarm_next = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         idleCnt_reg     <= '0;
         driverAlarm_reg <= 1'b0;
      end else begin
         idleCnt_reg     <= idleCnt_next;
         driverAlarm_reg <= driverAlarm_next;
      end
   end

   // registers and event capture
   event_vec_t      enable_reg;
   event_vec_t      enable_next;
   event_vec_t      status_reg;
   event_vec_t      status_next;
   event_vec_t      statusPrev_reg;
   event_vec_t      source_reg;
   event_vec_t      source_next;
   logic [1:0]      control_reg;
   logic [1:0]      control_next;
   logic            irq_reg;
   logic            irq_next;
   apb_state_e      apbState_reg;
   apb_state_e      apbState_next;
   apb_data_t       prdata_reg;
   apb_data_t       prdata_next;
   logic            pslverr_reg;
   logic            pslverr_next;
   logic            pready_reg;
   logic            pready_next;
   event_vec_t      changeEvt;
   event_vec_t      clearMask;
   logic            singleRail;
   logic            wrTake;
   logic            mapped;

   assign singleRail = control_reg[`LU_CTRL_SINGLE_RAIL];
   assign wrTake     = psel & penable & pwrite & (apbState_reg == APB_DONE);

   always_comb begin
      status_next = '0;
      status_next[`LU_BIT_DRIVER_ALARM] = driverAlarm_reg;
      status_next[`LU_BIT_FIFO_LIMIT]   = syncLvl[6];
      status_next[`LU_BIT_CODE_VIOL]    = syncLvl[5] | (control_reg[`LU_CTRL_B8ZS] & syncLvl[4]);
      status_next[`LU_BIT_LOOP_CODE]    = syncLvl[3];
      status_next[`LU_BIT_AIS]          = syncLvl[2];
      status_next[`LU_BIT_LOS]          = syncLvl[1];
      status_next[`LU_BIT_QRSS]         = syncLvl[0];
   end

   always_comb begin
      changeEvt = status_reg ^ statusPrev_reg;
      changeEvt[`LU_BIT_AIS] = status_reg[`LU_BIT_AIS] & ~statusPrev_reg[`LU_BIT_AIS];
      if (!singleRail) begin
         changeEvt = '0;
      end
   end

   always_comb begin
      clearMask = '0;
      if (wrTake && paddr == addrOf(`LU_IDX_CLEAR)) begin
         clearMask = pwdata[6:0];
      end
      // set wins over clear; masked events still latch
      source_next = (source_reg & ~clearMask) | changeEvt;
      irq_next    = singleRail && ((source_next & enable_reg) != '0);
   end

   always_comb begin
      enable_next  = enable_reg;
      control_next = control_reg;
      if (wrTake) begin
         if (paddr == addrOf(`LU_IDX_ENABLE)) begin
            enable_next = pwdata[6:0];
         end else if (paddr == addrOf(`LU_IDX_CONTROL)) begin
            control_next = pwdata[1:0];
         end
      end
   end

   // apb slave: one wait state, answer registered
   always_comb begin
      mapped = 1'b1;
      prdata_next = '0;
      if (paddr == addrOf(`LU_IDX_ENABLE)) begin
         prdata_next = {24'h000000, 1'b0, enable_reg};
      end else if (paddr == addrOf(`LU_IDX_STATUS)) begin
         prdata_next = {25'h0000000, status_reg};
      end else if (paddr == addrOf(`LU_IDX_SOURCE)) begin
         prdata_next = {25'h0000000, source_reg};
      end else if (paddr == addrOf(`LU_IDX_CLEAR)) begin
         prdata_next = '0;
      end else if (paddr == addrOf(`LU_IDX_CONTROL)) begin
         prdata_next = {30'h00000000, control_reg};
      end else begin
         mapped = 1'b0;
      end
      if (pwrite) begin
         prdata_next = '0;
      end
      if (pwrite && paddr == addrOf(`LU_IDX_STATUS)) begin
         mapped = 1'b0;
      end
      apbState_next = apbState_reg;
      pslverr_next  = 1'b0;
      case (apbState_reg)
         APB_IDLE: begin
            if (psel && penable) begin
               apbState_next = APB_DONE;
               pslverr_next  = ~mapped;
            end else begin
               prdata_next = '0;
            end
         end
         APB_WAIT: begin
            apbState_next = APB_IDLE;
            prdata_next   = '0;
         end
         APB_DONE: begin
            apbState_next = APB_IDLE;
            prdata_next   = '0;
         end
         default: begin
            apbState_next = APB_IDLE;
            prdata_next   = '0;
         end
      endcase
      pready_next = (apbState_next == APB_DONE);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         enable_reg     <= `LU_ENABLE_RESET;
         status_reg     <= '0;
         statusPrev_reg <= '0;
         source_reg     <= `LU_SOURCE_RESET;
         control_reg    <= `LU_CONTROL_RESET;
         irq_reg        <= 1'b0;
         apbState_reg   <= APB_IDLE;
         prdata_reg     <= '0;
         pslverr_reg    <= 1'b0;
         pready_reg     <= 1'b0;
      end else begin
         enable_reg     <= enable_next;
         status_reg     <= status_next;
         statusPrev_reg <= status_reg;
         source_reg     <= source_next;
         control_reg    <= control_next;
         irq_reg        <= irq_next;
         apbState_reg   <= apbState_next;
         prdata_reg     <= prdata_next;
         pslverr_reg    <= pslverr_next;
         pready_reg     <= pready_next;
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq     = irq_reg;

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_enable_top_zero;
      pready && !pwrite && paddr == addrOf(`LU_IDX_ENABLE) |-> prdata[7] == 1'b0;
   endproperty
   a_enable_top_zero: assert property (p_enable_top_zero) else $error("enable bit 7 read as one");

   property p_alarm_declare;
      !pulseLvl && tickRise && idleCnt_reg == IDLE_LIMIT - CW'(1) |=> driverAlarm_reg;
   endproperty
   a_alarm_declare: assert property (p_alarm_declare) else $error("driver alarm not declared");

   property p_alarm_early;
      driverAlarm_reg |-> idleCnt_reg == IDLE_LIMIT;
   endproperty
   a_alarm_early: assert property (p_alarm_early) else $error("driver alarm before idle limit");

   property p_alarm_clear;
      pulseLvl |=> !driverAlarm_reg && idleCnt_reg == '0;
   endproperty
   a_alarm_clear: assert property (p_alarm_clear) else $error("driver alarm kept after pulse");

   property p_change_latches;
      singleRail && (status_reg[`LU_BIT_DRIVER_ALARM] != statusPrev_reg[`LU_BIT_DRIVER_ALARM])
      |=> source_reg[`LU_BIT_DRIVER_ALARM];
   endproperty
   a_change_latches: assert property (p_change_latches) else $error("alarm change not latched");

   property p_ais_rise_only;
      $fell(status_reg[`LU_BIT_AIS]) && !source_reg[`LU_BIT_AIS] |=> !source_reg[`LU_BIT_AIS];
   endproperty
   a_ais_rise_only: assert property (p_ais_rise_only) else $error("ais clear raised an event");

   property p_irq_follows;
      ##1 irq == ($past(singleRail) && ((source_reg & $past(enable_reg)) != '0));
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("interrupt does not follow source and enable");

   property p_rail_gate;
      !singleRail |=> !irq && ((source_reg & ~$past(source_reg)) == '0);
   endproperty
   a_rail_gate: assert property (p_rail_gate) else $error("activity outside single rail");

   property p_viol_status;
      syncLvl[5] |=> status_reg[`LU_BIT_CODE_VIOL];
   endproperty
   a_viol_status: assert property (p_viol_status) else $error("violation status missing");

   property p_reset_enable;
      @(posedge mclk) disable iff (1'b0) !rst_n |-> enable_reg == '0;
   endproperty
   a_reset_enable: assert property (p_reset_enable) else $error("enable not cleared by reset");

   c_irq_rise: cover property ($rose(irq));
   c_alarm_rise: cover property ($rose(driverAlarm_reg));
   c_enable_write: cover property (wrTake && paddr == addrOf(`LU_IDX_ENABLE));
   c_set_and_clear: cover property (changeEvt != '0 && clearMask != '0);
endmodule

// ---- line_unit_interrupt_enables_bench.sv ----
`timescale 1ns/1ps
module line_unit_interrupt_enables_bench;
   import line_unit_irq_pkg::*;

   typedef struct {logic rd; logic [31:0] d; logic e;} note_s;

   logic        mclk;
   logic        rst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        txPulse;
   logic        txBitTick;
   logic        zeroRun;
   logic [5:0]  det;
   logic        irq;
   note_s       notes[$];
   int          failCount;
   int          compares;
   int          seed;
   logic [31:0] rv;

   line_unit_interrupt_enables #(.IDLE_BITS(4)) i_dut (
      .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .txPulse(txPulse), .txBitTick(txBitTick), .fifoLimit(det[5]), .codeViolation(det[4]),
      .zeroRun(zeroRun), .loopCodeDetect(det[3]), .aisDetect(det[2]), .signalLoss(det[1]),
      .patternDetect(det[0]), .irq(irq)
   );

   always #50 mclk = ~mclk;

   task automatic closeOut();
      if (failCount == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] ed, input logic ee);
      int n;
      notes.push_back('{~w, ed, ee});
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      @(posedge mclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 20) begin
         failCount++;
         $display("wrong value at %0t: no bus answer", $time);
         closeOut();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic chk(input logic act, input logic exp);
      compares++;
      if (act !== exp) begin
         failCount++;
         $display("wrong value at %0t: irq %b expected %b", $time, act, exp);
      end
   endtask

   task automatic settle();
      repeat (8) @(posedge mclk);
   endtask

   task automatic tick(input int k);
      repeat (k) begin
         txBitTick <= 1'b1;
         repeat (4) @(posedge mclk);
         txBitTick <= 1'b0;
         repeat (4) @(posedge mclk);
      end
   endtask

   // result watcher: oldest note against each bus answer
   always @(posedge mclk) begin
      note_s n;
      if (pready === 1'b1) begin
         if (notes.size() == 0) begin
            failCount++;
            $display("wrong value at %0t: unexpected answer", $time);
         end else begin
            n = notes.pop_front();
            compares++;
            if (pslverr !== n.e || (n.rd && prdata !== n.d)) begin
               failCount++;
               $display("wrong value at %0t: data %h err %b", $time, prdata, pslverr);
            end
         end
      end
   end

   initial begin
      mclk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; txPulse = 1'b0; txBitTick = 1'b0;
      zeroRun = 1'b0; det = 6'h00; failCount = 0; compares = 0; seed = 32'h55768cab;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      xfer(1'b0, 12'h010, 32'h0, 32'h0, 1'b0);
      xfer(1'b0, 12'h018, 32'h0, 32'h0, 1'b0);
      xfer(1'b0, 12'h020, 32'h0, 32'h0, 1'b0);
      rv = $random(seed);
      xfer(1'b1, 12'h010, rv, 32'h0, 1'b0);
      xfer(1'b0, 12'h010, 32'h0, {25'h0, rv[6:0]}, 1'b0);
      xfer(1'b1, 12'h010, 32'hff, 32'h0, 1'b0);
      xfer(1'b0, 12'h010, 32'h0, 32'h7f, 1'b0);
      xfer(1'b1, 12'h014, 32'hff, 32'h0, 1'b1);
      xfer(1'b0, 12'h0fc, 32'h0, 32'h0, 1'b1);
      // dual rail: enabled events stay silent
      det <= 6'h01;
      settle();
      chk(irq, 1'b0);
      xfer(1'b0, 12'h018, 32'h0, 32'h0, 1'b0);
      det <= 6'h00;
      settle();
      xfer(1'b1, 12'h01c, 32'h7f, 32'h0, 1'b0);
      xfer(1'b1, 12'h020, 32'h1, 32'h0, 1'b0);
      xfer(1'b1, 12'h010, 32'h0, 32'h0, 1'b0);
      for (int b = 0; b < 6; b++) begin
         det[b] <= 1'b1;
         settle();
         chk(irq, 1'b0);
         xfer(1'b0, 12'h014, 32'h0, 32'h1 << b, 1'b0);
         xfer(1'b0, 12'h018, 32'h0, 32'h1 << b, 1'b0);
         xfer(1'b1, 12'h01c, 32'h7f, 32'h0, 1'b0);
         xfer(1'b1, 12'h010, 32'h1 << b, 32'h0, 1'b0);
         det[b] <= 1'b0;
         settle();
         chk(irq, b != 2);
         xfer(1'b1, 12'h01c, 32'h7f, 32'h0, 1'b0);
         repeat (2) @(posedge mclk);
         chk(irq, 1'b0);
         det[b] <= 1'b1;
         settle();
         chk(irq, 1'b1);
         xfer(1'b1, 12'h010, 32'h0, 32'h0, 1'b0);
         repeat (2) @(posedge mclk);
         chk(irq, 1'b0);
         det[b] <= 1'b0;
         settle();
         xfer(1'b1, 12'h01c, 32'h7f, 32'h0, 1'b0);
      end
      // driver alarm needs an unbroken run of idle bit periods
      xfer(1'b1, 12'h010, 32'h40, 32'h0, 1'b0);
      tick(3);
      txPulse <= 1'b1;
      repeat (6) @(posedge mclk);
      txPulse <= 1'b0;
      tick(3);
      settle();
      chk(irq, 1'b0);
      tick(1);
      settle();
      chk(irq, 1'b1);
      xfer(1'b0, 12'h014, 32'h0, 32'h40, 1'b0);
      xfer(1'b1, 12'h01c, 32'h7f, 32'h0, 1'b0);
      txPulse <= 1'b1;
      settle();
      chk(irq, 1'b1);
      xfer(1'b0, 12'h014, 32'h0, 32'h0, 1'b0);
      xfer(1'b1, 12'h01c, 32'h7f, 32'h0, 1'b0);
      // long zero run counts as a violation only with B8ZS
      xfer(1'b1, 12'h010, 32'h10, 32'h0, 1'b0);
      zeroRun <= 1'b1;
      settle();
      chk(irq, 1'b0);
      xfer(1'b1, 12'h020, 32'h3, 32'h0, 1'b0);
      settle();
      chk(irq, 1'b1);
      xfer(1'b0, 12'h014, 32'h0, 32'h10, 1'b0);
      // reset in mid-run clears enables, control and the request
      xfer(1'b1, 12'h010, 32'h7f, 32'h0, 1'b0);
      rst_n <= 1'b0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      xfer(1'b0, 12'h010, 32'h0, 32'h0, 1'b0);
      xfer(1'b0, 12'h020, 32'h0, 32'h0, 1'b0);
      chk(irq, 1'b0);
      repeat (4) @(posedge mclk);
      closeOut();
   end
endmodule
